// ===== brtc_core.sv
// Calendar clock, retained memory with lockable ranges and date alarm.
`timescale 1ns/1ps
// Functional notes
// - Keep time of day from 32.768 kHz source.
// - Hold 256 retained bytes.
// - Two locked 8-byte ranges block reads, writes.
// - Date alarm raises wake up to month ahead.
// - Main reset clears all clock-domain bits except the retained bytes.
// - Secondary reset clears only manageability bits.
module brtc_core (
  // Clock and main clock-domain reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // Secondary manageability reset.
  input  wire logic        secondaryManageabilityResetN,
  // Oscillator pins.
  input  wire logic        oscIn,
  output logic             oscOut,
  // Time set.
  input  wire logic        setTime,
  input  wire logic [5:0]  setSec,
  input  wire logic [5:0]  setMin,
  input  wire logic [4:0]  setHour,
  input  wire logic [4:0]  setDay,
  input  wire logic [3:0]  setMonth,
  input  wire logic [6:0]  setYear,
  // Current time.
  output logic [5:0]       timeSec,
  output logic [5:0]       timeMin,
  output logic [4:0]       timeHour,
  output logic [4:0]       timeDay,
  output logic [3:0]       timeMonth,
  output logic [6:0]       timeYear,
  // Retained memory port.
  input  wire logic [7:0]  ramAddr,
  input  wire logic        ramWrEn,
  input  wire logic [7:0]  ramWrData,
  input  wire logic        ramRdEn,
  output logic [7:0]       ramRdData,
  output logic             ramRdValid,
  output logic             ramDenied,
  // Lock settings.
  input  wire logic        lockWr,
  input  wire logic [1:0]  lockOnIn,
  input  wire logic [4:0]  lockBase0In,
  input  wire logic [4:0]  lockBase1In,
  // Date alarm.
  input  wire logic        alarmEn,
  input  wire logic [4:0]  alarmDay,
  input  wire logic [4:0]  alarmHour,
  input  wire logic [5:0]  alarmMin,
  input  wire logic [5:0]  alarmSec,
  output logic             wakeEvent
);
  logic [7:0]  mem [brtc_pkg::RAM_BYTES];
  logic [5:0]  secReg;
  logic [5:0]  minReg;
  logic [4:0]  hourReg;
  logic [4:0]  dayReg;
  logic [3:0]  monthReg;
  logic [6:0]  yearReg;
  logic [1:0]  lockOnReg;
  logic [4:0]  lockBaseReg [brtc_pkg::LOCK_RANGES];
  logic [7:0]  rdDataReg;
  logic        rdValidReg;
  logic        deniedReg;
  logic        tickDlyReg;
  logic        wakeReg;
  logic        oscOutReg;
  logic        tick;
  logic [4:0]  daysInMonth;
  logic [1:0]  hitRange;
  wire         mgmtRstn;
  wire         blocked;
  wire         secWrap;
  wire         minWrap;
  wire         hourWrap;
  wire         dayWrap;
  wire         monthWrap;
  wire         alarmHit;

  brtc_tick_div u_tick (
    .clk  (clk),
    .rstn (rstn),
    .oscIn(oscIn),
    .tick (tick)
  );

  assign mgmtRstn = rstn & secondaryManageabilityResetN;

  for (genvar g = 0; g < brtc_pkg::LOCK_RANGES; g++) begin : g_lock
    assign hitRange[g] = lockOnReg[g] &&
      (ramAddr[brtc_pkg::ADDR_W-1:brtc_pkg::LOCK_LSB] == lockBaseReg[g]);
  end
  assign blocked = |hitRange;

  always_comb begin
    if (monthReg == brtc_pkg::MONTH_FEB) begin
      daysInMonth = (yearReg[1:0] == 2'h0) ? brtc_pkg::DAYS_29
                                           : brtc_pkg::DAYS_28;
    end else if (monthReg == brtc_pkg::MONTH_APR ||
                 monthReg == brtc_pkg::MONTH_JUN ||
                 monthReg == brtc_pkg::MONTH_SEP ||
                 monthReg == brtc_pkg::MONTH_NOV) begin
      daysInMonth = brtc_pkg::DAYS_30;
    end else begin
      daysInMonth = brtc_pkg::DAYS_31;
    end
  end

  assign secWrap   = (secReg == brtc_pkg::SEC_LAST);
  assign minWrap   = secWrap && (minReg == brtc_pkg::MIN_LAST);
  assign hourWrap  = minWrap && (hourReg == brtc_pkg::HOUR_LAST);
  assign dayWrap   = hourWrap && (dayReg == daysInMonth);
  assign monthWrap = dayWrap && (monthReg == brtc_pkg::MONTH_LAST);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      secReg   <= '0;
      minReg   <= '0;
      hourReg  <= '0;
      dayReg   <= brtc_pkg::DAY_FIRST;
      monthReg <= brtc_pkg::MONTH_FIRST;
      yearReg  <= '0;
    end else if (setTime) begin
      secReg   <= setSec;
      minReg   <= setMin;
      hourReg  <= setHour;
      dayReg   <= setDay;
      monthReg <= setMonth;
      yearReg  <= setYear;
    end else if (tick) begin
      secReg <= secWrap ? '0 : secReg + 1'b1;
      if (secWrap) minReg <= (minReg == brtc_pkg::MIN_LAST) ? '0
                                                             : minReg + 1'b1;
      if (minWrap) hourReg <= (hourReg == brtc_pkg::HOUR_LAST) ? '0
                                                               : hourReg + 1'b1;
      if (hourWrap) dayReg <= dayWrap ? brtc_pkg::DAY_FIRST : dayReg + 1'b1;
      if (dayWrap) monthReg <= monthWrap ? brtc_pkg::MONTH_FIRST
                                         : monthReg + 1'b1;
      if (monthWrap) yearReg <= (yearReg == brtc_pkg::YEAR_LAST) ? '0
                                                                 : yearReg + 1'b1;
    end
  end

  // lock settings are the manageability bits.
  always_ff @(posedge clk or negedge mgmtRstn) begin
    if (!mgmtRstn) begin
      lockOnReg      <= '0;
      lockBaseReg[0] <= '0;
      lockBaseReg[1] <= '0;
    end else if (lockWr) begin
      lockOnReg      <= lockOnIn;
      lockBaseReg[0] <= lockBase0In;
      lockBaseReg[1] <= lockBase1In;
    end
  end

  always_ff @(posedge clk) begin
    if (ramWrEn && !blocked) mem[ramAddr] <= ramWrData;
  end

  // blocked reads return zero and flag denial.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdDataReg  <= '0;
      rdValidReg <= 1'b0;
      deniedReg  <= 1'b0;
    end else begin
      rdValidReg <= ramRdEn;
      deniedReg  <= (ramRdEn || ramWrEn) && blocked;
      if (ramRdEn) rdDataReg <= blocked ? '0 : mem[ramAddr];
    end
  end

  // alarm compares the freshly advanced time.
  assign alarmHit = alarmEn && tickDlyReg && (dayReg == alarmDay) &&
                    (hourReg == alarmHour) && (minReg == alarmMin) &&
                    (secReg == alarmSec);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tickDlyReg <= 1'b0;
      wakeReg    <= 1'b0;
      oscOutReg  <= 1'b0;
    end else begin
      tickDlyReg <= tick;
      wakeReg    <= alarmHit;
      oscOutReg  <= 1'b0;
    end
  end

  assign oscOut     = oscOutReg;
  assign timeSec    = secReg;
  assign timeMin    = minReg;
  assign timeHour   = hourReg;
  assign timeDay    = dayReg;
  assign timeMonth  = monthReg;
  assign timeYear   = yearReg;
  assign ramRdData  = rdDataReg;
  assign ramRdValid = rdValidReg;
  assign ramDenied  = deniedReg;
  assign wakeEvent  = wakeReg;

  a_sec_advance: assert property (
    @(posedge clk) disable iff (!rstn)
    (tick && !setTime && !secWrap) |=> secReg == $past(secReg) + 6'h01)
    else $error("seconds did not advance on tick");
  a_sec_rollover: assert property (
    @(posedge clk) disable iff (!rstn)
    (tick && !setTime && secWrap) |=> secReg == '0 &&
      minReg != $past(minReg))
    else $error("seconds wrap did not carry");
  a_ram_store: assert property (
    @(posedge clk) disable iff (!rstn)
    (ramWrEn && !blocked) |=> mem[$past(ramAddr)] == $past(ramWrData))
    else $error("unblocked write not stored");
  a_lock_read: assert property (
    @(posedge clk) disable iff (!rstn)
    (ramRdEn && blocked) |=> ramRdValid && ramDenied && ramRdData == '0)
    else $error("locked read not blocked");
  a_alarm_wake: assert property (
    @(posedge clk) disable iff (!rstn)
    wakeEvent |-> $past(alarmEn) && $past(tick, 2) &&
      $past(secReg) == $past(alarmSec) && $past(dayReg) == $past(alarmDay))
    else $error("wake without alarm match");
  a_main_reset: assert property (
    @(posedge clk) disable iff (!rstn)
    !$past(rstn) |-> secReg == '0 && lockOnReg == '0 && !wakeEvent)
    else $error("main reset left state set");
  a_sec_lock_clear: assert property (
    @(posedge clk) disable iff (!rstn)
    !secondaryManageabilityResetN |-> lockOnReg == '0)
    else $error("secondary reset kept lock bits");
  a_sec_keep_time: assert property (
    @(posedge clk) disable iff (!rstn)
    (!secondaryManageabilityResetN && !tick && !setTime) |=>
      $stable(secReg) && $stable(dayReg))
    else $error("secondary reset disturbed time");
endmodule : brtc_core

// ===== brtc_pkg.sv
// Shared constants for the battery-backed clock with retained memory.
package brtc_pkg;
  localparam int unsigned CLK_HZ       = 10000000;
  localparam int unsigned OSC_HZ       = 32768;
  localparam int unsigned OSC_PER_TICK = OSC_HZ;
  localparam int unsigned EDGE_W       = 15;
  localparam logic [14:0] EDGE_LAST    = 15'h7fff;
  localparam int unsigned RAM_BYTES    = 256;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned LOCK_RANGES  = 2;
  localparam int unsigned LOCK_BASE_W  = 5;
  localparam int unsigned LOCK_LSB     = 3;
  localparam logic [5:0]  SEC_LAST     = 6'h3b;
  localparam logic [5:0]  MIN_LAST     = 6'h3b;
  localparam logic [4:0]  HOUR_LAST    = 5'h17;
  localparam logic [3:0]  MONTH_LAST   = 4'hc;
  localparam logic [6:0]  YEAR_LAST    = 7'h63;
  localparam logic [4:0]  DAY_FIRST    = 5'h01;
  localparam logic [3:0]  MONTH_FIRST  = 4'h1;
  localparam logic [3:0]  MONTH_FEB    = 4'h2;
  localparam logic [3:0]  MONTH_APR    = 4'h4;
  localparam logic [3:0]  MONTH_JUN    = 4'h6;
  localparam logic [3:0]  MONTH_SEP    = 4'h9;
  localparam logic [3:0]  MONTH_NOV    = 4'hb;
  localparam logic [4:0]  DAYS_28      = 5'h1c;
  localparam logic [4:0]  DAYS_29      = 5'h1d;
  localparam logic [4:0]  DAYS_30      = 5'h1e;
  localparam logic [4:0]  DAYS_31      = 5'h1f;
endpackage : brtc_pkg

// ===== brtc_tick_div.sv
// Oscillator pin synchroniser and once-per-second tick divider.
`timescale 1ns/1ps
module brtc_tick_div (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rstn,
  // Oscillator pin.
  input  wire logic oscIn,
  // One-cycle tick every second.
  output logic      tick
);
  logic                              sync1Reg;
  logic                              sync2Reg;
  logic                              sync3Reg;
  logic                              levelReg;
  logic [brtc_pkg::EDGE_W-1:0]       edgeCntReg;
  logic                              tickReg;
  wire                               oscRise;
  wire                               oscChange;
  wire                               lastEdge;

  assign oscChange = (sync2Reg == sync3Reg) && (sync3Reg != levelReg);
  assign oscRise   = oscChange && sync3Reg;
  assign lastEdge  = (edgeCntReg == brtc_pkg::EDGE_LAST);
  assign tick      = tickReg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1Reg <= 1'b0;
      sync2Reg <= 1'b0;
      sync3Reg <= 1'b0;
      levelReg <= 1'b0;
    end else begin
      sync1Reg <= oscIn;
      sync2Reg <= sync1Reg;
      sync3Reg <= sync2Reg;
      if (oscChange) levelReg <= sync3Reg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      edgeCntReg <= '0;
      tickReg    <= 1'b0;
    end else begin
      tickReg <= oscRise && lastEdge;
      if (oscRise) edgeCntReg <= edgeCntReg + 1'b1;
    end
  end

  a_tick_after_count: assert property (
    @(posedge clk) disable iff (!rstn)
    tick |-> $past(edgeCntReg) == brtc_pkg::EDGE_LAST && $past(oscRise))
    else $error("tick without full edge count");
  a_tick_on_count: assert property (
    @(posedge clk) disable iff (!rstn)
    (oscRise && lastEdge) |=> tick && edgeCntReg == '0)
    else $error("full edge count gave no tick");
endmodule : brtc_tick_div

// ===== brtc_plat_seq.sv
// Platform sequencing model that drives the resets and the oscillator pin.
`timescale 1ns/1ps
module brtc_plat_seq (
  // Clock and requests from the bench.
  input  wire logic clk,
  input  wire logic mainClr,
  input  wire logic mgmtClr,
  input  wire logic oscRun,
  // Resets, power good and source.
  output logic      rstn,
  output logic      secondaryManageabilityResetN,
  output logic      deepSleepWellPowerGood,
  output logic      oscIn
);
  logic [4:0] upCnt;
  logic [1:0] oscCnt;
  wire        upDone = (upCnt == 5'h14);

  initial begin
    upCnt = 5'h00;
    oscCnt = 2'h0;
    rstn = 1'b0;
    secondaryManageabilityResetN = 1'b0;
    deepSleepWellPowerGood = 1'b0;
    oscIn = 1'b0;
  end
  // main reset low only at power-up or on a clear request.
  always @(posedge clk) begin
    upCnt <= upDone ? upCnt : upCnt + 5'h01;
    rstn <= upDone && !mainClr;
  end
  // secondary reset driven apart from the main reset.
  always @(posedge clk) secondaryManageabilityResetN <= upDone && !mgmtClr;
  // power good follows both resets being released.
  always @(posedge clk)
    deepSleepWellPowerGood <= rstn && secondaryManageabilityResetN;
  // source toggles every two clocks; it rests low while stopped.
  always @(posedge clk) begin
    oscCnt <= oscRun ? oscCnt + 2'h1 : 2'h0;
    oscIn <= oscRun && oscCnt[1];
  end
endmodule : brtc_plat_seq

// ===== brtc_core_tb.sv
// Self-checking bench for the calendar clock with retained memory.
`timescale 1ns/1ps
module brtc_core_tb;
  logic clk, mainClr, mgmtClr, oscRun, rstn, oscIn, oscOut;
  logic secondaryManageabilityResetN, deepSleepWellPowerGood;
  logic setTime, ramWrEn, ramRdEn, ramRdValid, ramDenied, lockWr;
  logic alarmEn, wakeEvent;
  logic [5:0] setSec, setMin, timeSec, timeMin, alarmMin, alarmSec;
  logic [4:0] setHour, setDay, timeHour, timeDay, alarmDay, alarmHour;
  logic [3:0] setMonth, timeMonth;
  logic [6:0] setYear, timeYear;
  logic [7:0] ramAddr, ramWrData, ramRdData;
  logic [1:0] lockOnIn;
  logic [4:0] lockBase0In, lockBase1In;
  logic [7:0] mem [256];
  logic [32:0] t0;
  int errCount, nCompared, edgeCnt, n;
  int lockBase [2];
  bit lockOn [2];
  integer seed;
  wire [32:0] timeNow = {timeSec, timeMin, timeHour, timeDay, timeMonth,
                         timeYear};

  brtc_core DUT (.*);
  brtc_plat_seq u_plat (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge oscIn) edgeCnt++;

  task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  function automatic bit isLocked(int a);
    return (lockOn[0] && a / 8 == lockBase[0]) ||
           (lockOn[1] && a / 8 == lockBase[1]);
  endfunction : isLocked

  task automatic setClock(logic [32:0] t);
    @(posedge clk);
    setTime <= 1'b1;
    {setSec, setMin, setHour, setDay, setMonth, setYear} <= t;
    @(posedge clk);
    setTime <= 1'b0;
    #1 check("time set", timeNow, t);
  endtask : setClock

  task automatic access(bit wr, int a, logic [7:0] d);
    bit lk;
    lk = isLocked(a);
    @(posedge clk);
    ramAddr <= a[7:0];
    ramWrEn <= wr;
    ramRdEn <= !wr;
    ramWrData <= d;
    @(posedge clk);
    ramWrEn <= 1'b0;
    ramRdEn <= 1'b0;
    #1 check("denied", ramDenied, lk);
    if (!wr) begin
      check("valid", ramRdValid, 1'b1);
      check("rd data", ramRdData, lk ? 8'h00 : mem[a]);
    end else if (!lk)
      mem[a] = d;
  endtask : access

  task automatic setLocks(logic [1:0] on);
    @(posedge clk);
    lockWr <= 1'b1;
    lockOnIn <= on;
    lockBase0In <= lockBase[0][4:0];
    lockBase1In <= lockBase[1][4:0];
    @(posedge clk);
    lockWr <= 1'b0;
    lockOn[0] = on[0];
    lockOn[1] = on[1];
  endtask : setLocks

  initial begin
    #20000000;
    errCount++;
    complete_run();
  end

  initial begin
    {mainClr, mgmtClr, oscRun, setTime, ramWrEn, ramRdEn, lockWr} = 7'h00;
    {setSec, setMin, setHour, setDay, setMonth, setYear} = 33'h0;
    {ramAddr, ramWrData, lockOnIn, lockBase0In, lockBase1In} = 28'h0;
    {alarmEn, alarmDay, alarmHour, alarmMin, alarmSec} = 23'h0;
    seed = 32'he63a7d02;
    wait (deepSleepWellPowerGood);
    @(posedge clk);
    #1 check("reset time", timeNow, {17'h0, 5'h01, 4'h1, 7'h00});
    check("reset wake", wakeEvent, 1'b0);
    check("osc out", oscOut, 1'b0);
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      ramWrEn <= 1'b1;
      ramAddr <= i[7:0];
      mem[i] = 8'($random(seed));
      ramWrData <= mem[i];
    end
    @(posedge clk);
    ramWrEn <= 1'b0;
    for (int i = 0; i < 256; i++) access(0, i, 8'h00);
    lockBase[0] = $random(seed) & 31;
    lockBase[1] = (lockBase[0] + 1) % 32;
    for (int m = 1; m < 4; m++) begin
      setLocks(m[1:0]);
      for (int r = 0; r < 2; r++)
        for (int k = -1; k < 9; k++) begin
          access(1, (lockBase[r] * 8 + k) & 255, $random(seed));
          access(0, (lockBase[r] * 8 + k) & 255, 8'h00);
        end
    end
    setClock({6'h15, 6'h2a, 5'h0c, 5'h0e, 4'h7, 7'h2d});
    t0 = timeNow;
    @(posedge clk);
    mgmtClr <= 1'b1;
    repeat (3) @(posedge clk);
    mgmtClr <= 1'b0;
    lockOn[0] = 0;
    lockOn[1] = 0;
    repeat (3) @(posedge clk);
    #1 check("time kept", timeNow, t0);
    for (int k = 0; k < 8; k++) access(0, lockBase[0] * 8 + k, 8'h00);
    setClock({6'h3b, 6'h3b, 5'h17, 5'h1f, 4'hc, 7'h03});
    @(posedge clk);
    alarmEn <= 1'b1;
    {alarmDay, alarmHour, alarmMin, alarmSec} <= {5'h01, 17'h0};
    edgeCnt = 0;
    oscRun <= 1'b1;
    #1;
    for (n = 0; n < 140000 && timeSec == 6'h3b; n++) #100;
    check("tick edges", edgeCnt >= 32768 && edgeCnt <= 32770, 1'b1);
    check("rollover", timeNow, {17'h0, 5'h01, 4'h1, 7'h04});
    @(posedge clk);
    #1 check("wake", wakeEvent, 1'b1);
    @(posedge clk);
    #1 check("wake end", wakeEvent, 1'b0);
    oscRun <= 1'b0;
    mainClr <= 1'b1;
    repeat (3) @(posedge clk);
    mainClr <= 1'b0;
    wait (deepSleepWellPowerGood);
    @(posedge clk);
    #1 check("main reset", timeNow, {17'h0, 5'h01, 4'h1, 7'h00});
    for (int k = 0; k < 16; k++)
      access(0, (lockBase[0] * 8 + k) & 255, 8'h00);
    complete_run();
  end
endmodule : brtc_core_tb
